// File: logic/pdc_bank.sv
// Power-down and analog PLL configuration register bank
// Operation
// - Lock override resets to 0 for automatic locking; 1 selects manual locking.
// - Oscillator select resets to 001; 000 first, 001 second, others reserved.
// - Five-bit manual lock value drives the oscillator in manual mode, resets 01011.
// - Pump current code resets 00000; each code maps to a fixed current.
// - Reserved bits must be written zero; their read value is undefined; this bank reads them as zero.
// - Each input reference disable bit resets 0; 1 disables that reference.
// - Release mode 0 clears alarm on lock; 1 also waits for stable outputs.
// - Doubler disable 0 uses twice crystal frequency; 1 uses it undoubled.
// - Output pair disable resets 0; 1 disables its logic and tristates driver.
// - Digital loop disable resets 0; writing 1 disables the digital loop.
// - Modulator disable resets 0; writing 1 disables the delta-sigma modulator.
// - Calibration hold resets 0; writing 1 holds calibration logic disabled.
// - Counter length selects 16-bit (0) or 20-bit (1) accumulator; resets 1.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"

module pdc_bank
	import pdc_pkg::*;
#(
	parameter int NUM_INPUTS = 2,
	parameter int NUM_OUTPUTS = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port from the serial interface logic
	input wire pdc_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Analog status, asynchronous to clk
	input wire logic pll_locked,
	input wire logic outputs_stable,
	// Controls to the clock path
	output pdc_pll_ctrl_t pll_ctrl,
	output logic [NUM_INPUTS-1:0] ref_input_off,
	output logic [NUM_OUTPUTS-1:0] output_pair_off,
	output logic [NUM_OUTPUTS-1:0] output_drive_oe_n,
	output logic [4:0] lock_acc_width,
	output logic [11:0] pump_current_ua,
	output logic osc_one_active,
	output logic loss_of_lock_alarm
);

	// Refused while elaborating: one data byte holds at most eight channel bits
	if (NUM_INPUTS < 1 || NUM_INPUTS > 8 || NUM_OUTPUTS < 1 || NUM_OUTPUTS > 8)
	begin : g_bad_counts
		$error("pdc_bank: channel counts must be 1 to 8");
	end

	pdc_pll_ctrl_t ctrl, next_ctrl;
	logic [NUM_INPUTS-1:0] in_off, next_in_off;
	logic [NUM_OUTPUTS-1:0] out_off, next_out_off;
	logic [7:0] next_rdata;
	logic lock_meta, lock_sync, stable_meta, stable_sync;
	logic alarm, next_alarm;
	logic [11:0] pump_ua, next_pump_ua;
	logic [4:0] acc_w, next_acc_w;
	logic osc_one, next_osc_one;

	// Codes 0-15 step 110 uA; codes 16-31 step 165 uA (half step more)
	function automatic logic [11:0] pump_lookup(input logic [4:0] code);
		logic [11:0] steps;
		steps = {8'h00, code[3:0]} + 12'h001;
		if (code[4])
			pump_lookup = 12'(steps * `PDC_PUMP_STEP_UA + steps * `PDC_PUMP_HALF_UA);
		else
			pump_lookup = 12'(steps * `PDC_PUMP_STEP_UA);
	endfunction : pump_lookup

	// Register writes and read mux; undefined bits answer zero
	always_comb
	begin
		next_ctrl = ctrl;
		next_in_off = in_off;
		next_out_off = out_off;
		next_rdata = 8'h00;
		if (reg_req.wr_en)
		begin
			if (reg_req.addr == `PDC_OFS_LOCK_CFG)
			begin
				next_ctrl.lock_override_sel = reg_req.wdata[`PDC_BIT_LOCK_OVERRIDE];
				next_ctrl.lock_counter_length = reg_req.wdata[`PDC_BIT_COUNTER_LEN];
			end
			else if (reg_req.addr == `PDC_OFS_OSC_CFG)
			begin
				next_ctrl.manual_osc_sel = reg_req.wdata[`PDC_LSB_OSC_SEL +: 3];
				next_ctrl.manual_lock_value = reg_req.wdata[`PDC_LSB_MANUAL_LOCK +: 5];
			end
			else if (reg_req.addr == `PDC_OFS_PUMP_CFG)
				next_ctrl.pump_current_code = reg_req.wdata[`PDC_LSB_PUMP +: 5];
			else if (reg_req.addr == `PDC_OFS_INPUT_DIS)
				next_in_off = reg_req.wdata[NUM_INPUTS-1:0];
			else if (reg_req.addr == `PDC_OFS_LOCK_DBL)
			begin
				next_ctrl.alarm_release_mode = reg_req.wdata[`PDC_BIT_RELEASE_MODE];
				next_ctrl.crystal_doubler_off = reg_req.wdata[`PDC_BIT_DOUBLER_OFF];
			end
			else if (reg_req.addr == `PDC_OFS_OUTPUT_DIS)
				next_out_off = reg_req.wdata[NUM_OUTPUTS-1:0];
			else if (reg_req.addr == `PDC_OFS_BLOCK_DIS)
			begin
				next_ctrl.digital_loop_off = reg_req.wdata[`PDC_BIT_DPLL_OFF];
				next_ctrl.delta_sigma_off = reg_req.wdata[`PDC_BIT_DSM_OFF];
				next_ctrl.calibration_hold = reg_req.wdata[`PDC_BIT_CAL_HOLD];
			end
		end
		// Reserved bits are not stored, so they always read as zero
		if (reg_req.addr == `PDC_OFS_LOCK_CFG)
		begin
			next_rdata[`PDC_BIT_LOCK_OVERRIDE] = ctrl.lock_override_sel;
			next_rdata[`PDC_BIT_COUNTER_LEN] = ctrl.lock_counter_length;
		end
		else if (reg_req.addr == `PDC_OFS_OSC_CFG)
		begin
			next_rdata[`PDC_LSB_OSC_SEL +: 3] = ctrl.manual_osc_sel;
			next_rdata[`PDC_LSB_MANUAL_LOCK +: 5] = ctrl.manual_lock_value;
		end
		else if (reg_req.addr == `PDC_OFS_PUMP_CFG)
			next_rdata[`PDC_LSB_PUMP +: 5] = ctrl.pump_current_code;
		else if (reg_req.addr == `PDC_OFS_INPUT_DIS)
			next_rdata[NUM_INPUTS-1:0] = in_off;
		else if (reg_req.addr == `PDC_OFS_LOCK_DBL)
		begin
			next_rdata[`PDC_BIT_RELEASE_MODE] = ctrl.alarm_release_mode;
			next_rdata[`PDC_BIT_DOUBLER_OFF] = ctrl.crystal_doubler_off;
		end
		else if (reg_req.addr == `PDC_OFS_OUTPUT_DIS)
			next_rdata[NUM_OUTPUTS-1:0] = out_off;
		else if (reg_req.addr == `PDC_OFS_BLOCK_DIS)
		begin
			next_rdata[`PDC_BIT_DPLL_OFF] = ctrl.digital_loop_off;
			next_rdata[`PDC_BIT_DSM_OFF] = ctrl.delta_sigma_off;
			next_rdata[`PDC_BIT_CAL_HOLD] = ctrl.calibration_hold;
		end
		if (!reg_req.rd_en)
			next_rdata = reg_rdata;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl.lock_override_sel <= `PDC_RST_LOCK_OVERRIDE;
			ctrl.lock_counter_length <= `PDC_RST_COUNTER_LEN;
			ctrl.manual_osc_sel <= `PDC_RST_OSC_SEL;
			ctrl.manual_lock_value <= `PDC_RST_MANUAL_LOCK;
			ctrl.pump_current_code <= `PDC_RST_PUMP;
			ctrl.alarm_release_mode <= 1'b0;
			ctrl.crystal_doubler_off <= 1'b0;
			ctrl.digital_loop_off <= 1'b0;
			ctrl.delta_sigma_off <= 1'b0;
			ctrl.calibration_hold <= 1'b0;
			in_off <= '0;
			out_off <= '0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			ctrl <= next_ctrl;
			in_off <= next_in_off;
			out_off <= next_out_off;
			reg_rdata <= next_rdata;
		end
	end

	// Status pins cross in from the analog side
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
			stable_meta <= 1'b0;
			stable_sync <= 1'b0;
		end
		else
		begin
			lock_meta <= pll_locked;
			lock_sync <= lock_meta;
			stable_meta <= outputs_stable;
			stable_sync <= stable_meta;
		end
	end

	// Derived controls, registered so outputs come from flip-flops
	always_comb
	begin
		next_alarm = !(lock_sync && (!ctrl.alarm_release_mode || stable_sync));
		next_acc_w = ctrl.lock_counter_length ? `PDC_ACC_LONG : `PDC_ACC_SHORT;
		next_pump_ua = pump_lookup(ctrl.pump_current_code);
		// Reserved codes fall back to the first oscillator
		next_osc_one = (ctrl.manual_osc_sel == `PDC_OSC_ONE);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alarm <= 1'b1;
			acc_w <= `PDC_ACC_LONG;
			pump_ua <= `PDC_PUMP_STEP_UA;
			osc_one <= 1'b1;
		end
		else
		begin
			alarm <= next_alarm;
			acc_w <= next_acc_w;
			pump_ua <= next_pump_ua;
			osc_one <= next_osc_one;
		end
	end

	assign pll_ctrl = ctrl;
	assign ref_input_off = in_off;
	assign output_pair_off = out_off;
	assign output_drive_oe_n = out_off;
	assign lock_acc_width = acc_w;
	assign pump_current_ua = pump_ua;
	assign osc_one_active = osc_one;
	assign loss_of_lock_alarm = alarm;

endmodule : pdc_bank

`default_nettype wire

// File: logic/pdc_consts.svh
// Offsets, field positions, reset values and figures of the power-down configuration bank
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_ADDR_W 16
`define PDC_OFS_LOCK_CFG 16'h0069
`define PDC_OFS_OSC_CFG 16'h006a
`define PDC_OFS_PUMP_CFG 16'h006c
`define PDC_OFS_INPUT_DIS 16'h006d
`define PDC_OFS_LOCK_DBL 16'h006e
`define PDC_OFS_OUTPUT_DIS 16'h006f
`define PDC_OFS_BLOCK_DIS 16'h0070

`define PDC_BIT_LOCK_OVERRIDE 0
`define PDC_BIT_COUNTER_LEN 1
`define PDC_LSB_MANUAL_LOCK 0
`define PDC_LSB_OSC_SEL 5
`define PDC_LSB_PUMP 0
`define PDC_BIT_DOUBLER_OFF 0
`define PDC_BIT_RELEASE_MODE 1
`define PDC_BIT_CAL_HOLD 0
`define PDC_BIT_DSM_OFF 1
`define PDC_BIT_DPLL_OFF 2

`define PDC_RST_LOCK_OVERRIDE 1'b0
`define PDC_RST_COUNTER_LEN 1'b1
`define PDC_RST_OSC_SEL 3'h1
`define PDC_RST_MANUAL_LOCK 5'h0b
`define PDC_RST_PUMP 5'h00
`define PDC_OSC_ZERO 3'h0
`define PDC_OSC_ONE 3'h1

`define PDC_ACC_SHORT 5'h10
`define PDC_ACC_LONG 5'h14
`define PDC_PUMP_STEP_UA 12'h06e
`define PDC_PUMP_HALF_UA 12'h037

`endif

// File: logic/pdc_pkg.sv
// Types shared by the power-down configuration bank
`default_nettype none
package pdc_pkg;

	typedef struct packed {
		logic lock_override_sel;
		logic lock_counter_length;
		logic [2:0] manual_osc_sel;
		logic [4:0] manual_lock_value;
		logic [4:0] pump_current_code;
		logic alarm_release_mode;
		logic crystal_doubler_off;
		logic digital_loop_off;
		logic delta_sigma_off;
		logic calibration_hold;
	} pdc_pll_ctrl_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [15:0] addr;
		logic [7:0] wdata;
	} pdc_reg_req_t;

endpackage : pdc_pkg

`default_nettype wire

// File: tb/pdc_bank_assertions.sv
// Concurrent checks on the ports of the power-down configuration bank
`timescale 1ns/1ps
`default_nettype none
module pdc_bank_chk
	import pdc_pkg::*;
#(
	parameter int NUM_INPUTS = 2,
	parameter int NUM_OUTPUTS = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire pdc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	// Status and controls
	input wire logic pll_locked,
	input wire logic outputs_stable,
	input wire pdc_pll_ctrl_t pll_ctrl,
	input wire logic [NUM_INPUTS-1:0] ref_input_off,
	input wire logic [NUM_OUTPUTS-1:0] output_pair_off,
	input wire logic [NUM_OUTPUTS-1:0] output_drive_oe_n,
	input wire logic [4:0] lock_acc_width,
	input wire logic osc_one_active,
	input wire logic loss_of_lock_alarm
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_oe; output_drive_oe_n == output_pair_off; endproperty
	a_oe: assert property (p_oe) else $error("driver enable off");
	property p_acc; lock_acc_width == ($past(pll_ctrl.lock_counter_length) ? 5'h14 : 5'h10); endproperty
	a_acc: assert property (p_acc) else $error("accumulator width");
	property p_osc; osc_one_active == ($past(pll_ctrl.manual_osc_sel) == 3'h1); endproperty
	a_osc: assert property (p_osc) else $error("oscillator flag");
	property p_out;
		reg_req.wr_en && reg_req.addr == 16'h006f |=> output_pair_off == $past(reg_req.wdata[NUM_OUTPUTS-1:0]);
	endproperty
	a_out: assert property (p_out) else $error("output disable write");
	property p_blk;
		reg_req.wr_en && reg_req.addr == 16'h0070 |=>
			{pll_ctrl.digital_loop_off, pll_ctrl.delta_sigma_off, pll_ctrl.calibration_hold} == $past(reg_req.wdata[2:0]);
	endproperty
	a_blk: assert property (p_blk) else $error("block disable write");
	property p_rd; reg_req.rd_en && reg_req.addr == 16'h006d |=> reg_rdata[1:0] == $past(ref_input_off); endproperty
	a_rd: assert property (p_rd) else $error("input disable read");
	property p_lock; (pll_locked && !pll_ctrl.alarm_release_mode)[*4] |-> !loss_of_lock_alarm; endproperty
	a_lock: assert property (p_lock) else $error("alarm held after lock");
	property p_wait;
		(pll_locked && !outputs_stable && pll_ctrl.alarm_release_mode)[*4] |-> loss_of_lock_alarm;
	endproperty
	a_wait: assert property (p_wait) else $error("alarm released early");
	c_out: cover property (reg_req.wr_en && reg_req.addr == 16'h006f ##1 output_pair_off != '0);
	c_rd: cover property (reg_req.rd_en ##1 reg_rdata != 8'h00);
	c_fall: cover property ($fell(loss_of_lock_alarm));
endmodule : pdc_bank_chk
bind pdc_bank pdc_bank_chk #(.NUM_INPUTS(NUM_INPUTS), .NUM_OUTPUTS(NUM_OUTPUTS)) chk_u (.clk, .rst, .reg_req,
	.reg_rdata, .pll_locked, .outputs_stable, .pll_ctrl, .ref_input_off, .output_pair_off, .output_drive_oe_n,
	.lock_acc_width, .osc_one_active, .loss_of_lock_alarm);
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the power-down configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pdc_pkg::*;
;
	localparam logic [15:0] ADR [7] = '{16'h0069, 16'h006a, 16'h006c, 16'h006d, 16'h006e, 16'h006f, 16'h0070};
	localparam logic [7:0] MSK [7] = '{8'h03, 8'hff, 8'h1f, 8'h03, 8'h03, 8'h0f, 8'h07};
	localparam logic [7:0] DEF [7] = '{8'h02, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Mode, locked, stable, expected alarm
	localparam logic [3:0] ALM [4] = '{4'h4, 4'hd, 4'he, 4'hb};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pll_locked = 1'b0;
	logic outputs_stable = 1'b0;
	pdc_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	pdc_pll_ctrl_t pll_ctrl;
	logic [1:0] ref_input_off;
	logic [3:0] output_pair_off;
	logic [3:0] output_drive_oe_n;
	logic [4:0] lock_acc_width;
	logic [11:0] pump_current_ua;
	logic osc_one_active;
	logic loss_of_lock_alarm;
	logic [7:0] mem [7];
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	pdc_bank dut_u (.clk, .rst, .reg_req, .reg_rdata, .pll_locked, .outputs_stable, .pll_ctrl, .ref_input_off,
		.output_pair_off, .output_drive_oe_n, .lock_acc_width, .pump_current_ua, .osc_one_active, .loss_of_lock_alarm);
	initial
	begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	function automatic logic [11:0] pump_ua(input logic [4:0] c);
		return c[4] ? 12'((c - 5'h0f) * 165) : 12'((c + 5'h01) * 110);
	endfunction : pump_ua
	task automatic cmp(input logic [11:0] g, e, input string s);
		checked++;
		if (g !== e)
			$display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
		if (g !== e)
			n_mismatch++;
	endtask : cmp
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk) reg_req = '{1'b1, 1'b0, a, d};
		@(negedge clk) reg_req = '0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) reg_req = '0;
		d = reg_rdata;
	endtask : rd
	task automatic readall;
		logic [7:0] d;
		for (int i = 0; i < 7; i++)
		begin
			rd(ADR[i], d);
			cmp(d & MSK[i], mem[i], "read back");
		end
		cmp(output_drive_oe_n, mem[5][3:0], "driver enable");
		cmp(ref_input_off, mem[3][1:0], "input off");
		cmp({pll_ctrl.alarm_release_mode, pll_ctrl.crystal_doubler_off}, mem[4][1:0], "mode");
		cmp(lock_acc_width, mem[0][1] ? 12'h014 : 12'h010, "accumulator");
		cmp(output_pair_off, mem[5][3:0], "output off");
		cmp({pll_ctrl.lock_counter_length, pll_ctrl.lock_override_sel}, mem[0][1:0], "lock config");
		cmp(pll_ctrl[2:0], mem[6][2:0], "block off");
	endtask : readall
	task automatic defaults;
		mem = DEF;
		readall();
		cmp(pump_current_ua, 12'h06e, "reset pump");
		cmp(osc_one_active, 12'h001, "reset oscillator");
		cmp(loss_of_lock_alarm, 12'h001, "reset alarm");
	endtask : defaults
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial
	begin
		logic [7:0] v;
		int j;
		void'($urandom(52723));
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		defaults();
		$display("test reset values done");
		for (int c = 0; c < 32; c++)
		begin
			v = 8'(c);
			wr(16'h006c, v);
			wr(16'h006a, {v[2:0], v[4:0]});
			@(negedge clk);
			cmp(pump_current_ua, pump_ua(v[4:0]), "pump current");
			cmp(osc_one_active, v[2:0] == 3'h1, "oscillator flag");
			cmp(pll_ctrl.manual_lock_value, v[4:0], "manual lock");
		end
		mem[1] = 8'hff;
		mem[2] = 8'h1f;
		$display("test code tables done");
		for (int n = 0; n < 40; n++)
		begin
			j = $urandom % 7;
			v = 8'($urandom) & MSK[j];
			wr(ADR[j], v);
			mem[j] = v;
			if (n % 8 == 7)
				readall();
		end
		wr(16'h0071, 8'h01);
		rd(16'h0071, v);
		cmp(v, 8'h00, "unmapped read");
		readall();
		$display("test random access done");
		foreach (ALM[k])
		begin
			wr(16'h006e, {6'h00, ALM[k][3], 1'b0});
			{pll_locked, outputs_stable} = ALM[k][2:1];
			repeat (4) @(negedge clk);
			cmp(loss_of_lock_alarm, ALM[k][0], "alarm");
		end
		$display("test alarm release done");
		{rst, pll_locked} = 2'b10;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		defaults();
		$display("test second reset done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
